// File: src/hc_irq_pkg.sv
// constants shared by the host controller interrupt and state logic
package hc_irq_pkg;
	// command indices (read index; write index has bit 7 set)
	localparam logic [7:0] IDX_CONTROL  = 8'h01;
	localparam logic [7:0] IDX_CMDSTAT  = 8'h02;
	localparam logic [7:0] IDX_CORE_ST  = 8'h03;
	localparam logic [7:0] IDX_CORE_EN  = 8'h04;
	localparam logic [7:0] IDX_FMINT    = 8'h0d;
	localparam logic [7:0] IDX_HWCFG    = 8'h20;
	localparam logic [7:0] IDX_PROC_ST  = 8'h24;
	localparam logic [7:0] IDX_PROC_EN  = 8'h25;
	localparam logic [7:0] IDX_ISO_LEN  = 8'h2a;
	localparam logic [7:0] IDX_GEN_LEN  = 8'h2b;
	localparam logic [7:0] IDX_BUFFER   = 8'h40;
	localparam logic [7:0] WRITE_FLAG   = 8'h80;
	localparam logic [7:0] CMD_SOFT_RST = 8'ha9;
	// field positions
	localparam int FS_LSB        = 6;
	localparam int CORE_RST_BIT  = 0;
	localparam int MASTER_EN_BIT = 31;
	localparam int PIN_EN_BIT    = 0;
	localparam int TRIG_BIT      = 1;
	localparam int POL_BIT       = 2;
	localparam int SUMMARY_BIT   = 5;
	// functional state codes
	localparam logic [1:0] FS_BUS_RESET = 2'h0;
	localparam logic [1:0] FS_WAKING    = 2'h1;
	localparam logic [1:0] FS_RUNNING   = 2'h2;
	localparam logic [1:0] FS_SLEEPING  = 2'h3;
	// descriptor header: four 16-bit words, word 0 first
	localparam int HDR_WORDS   = 4;
	localparam int HDR_CC_LSB  = 12;
	localparam int HDR_ACT_BIT = 11;
	localparam int HDR_TGL_BIT = 10;
	localparam int HDR_LAST    = 11;
	localparam int HDR_SPEED   = 10;
	localparam int HDR_EP_LSB  = 12;
	localparam int HDR_PID_LSB = 10;
	// reset values
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
	localparam logic [15:0] RST_WORD16 = 16'h0000;
	localparam logic [31:0] RST_FMINT  = 32'h0000_2edf;
	localparam int          GROUP_N    = 6;
endpackage : hc_irq_pkg

// File: src/irq_group.sv
// one interrupt group: sticky event bits, enables, gated summary
`timescale 1ns/1ps
`default_nettype none
module irq_group #(
	parameter int N = 6
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         clr_all,
	input  wire logic [N-1:0] events,
	input  wire logic         clr_we,
	input  wire logic [N-1:0] clr_bits,
	input  wire logic [N-1:0] enable,
	input  wire logic         gate,
	output logic      [N-1:0] status,
	output logic              summary
);
	typedef struct packed {
		logic [N-1:0] st;
	} group_s;
	group_s s;
	group_s next_s;

	always_comb begin
		next_s = s;
		if (clr_we)
			next_s.st = s.st & ~clr_bits;
		// an event in a clr_we clearing cycle survives; clr_all wins over it
		next_s.st = next_s.st | events;
		if (clr_all)
			next_s.st = '0;
	end

	always_ff @(posedge clk) begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign status  = s.st;
	assign summary = gate & |(s.st & enable);
endmodule : irq_group
`default_nettype wire

// File: src/buffer_ram.sv
// dual-port word memory holding descriptor records and payloads
`timescale 1ns/1ps
`default_nettype none
module buffer_ram #(
	parameter int AW = 11,
	parameter int DW = 16
) (
	input  wire logic          clk,
	input  wire logic          ce,
	input  wire logic          a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [DW-1:0] a_wdata,
	output logic      [DW-1:0] a_rdata,
	input  wire logic          b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [DW-1:0] b_wdata,
	output logic      [DW-1:0] b_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (a_we)
				mem[a_addr] <= a_wdata;
			if (b_we)
				mem[b_addr] <= b_wdata;
			a_rdata <= mem[a_addr];
			b_rdata <= mem[b_addr];
		end
	end
endmodule : buffer_ram
`default_nettype wire

// File: src/hc_irq_state_ctrl.sv
// host controller register port, interrupt tree, functional state and descriptor walker
`timescale 1ns/1ps
`default_nettype none
module hc_irq_state_ctrl #(
	parameter int AW = 11
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        cs_n,
	input  wire logic        a0,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out,
	output logic             data_oe,
	output logic             int_pin,
	input  wire logic [5:0]  core_events,
	input  wire logic [4:0]  proc_events,
	input  wire logic        frame_tick,
	output logic             txn_req,
	output logic      [6:0]  txn_func_addr,
	output logic      [3:0]  txn_endpoint,
	output logic      [1:0]  txn_pid,
	output logic      [9:0]  txn_length,
	output logic      [9:0]  txn_max_packet,
	output logic             txn_toggle,
	output logic             txn_low_speed,
	input  wire logic        txn_done,
	input  wire logic [3:0]  txn_code,
	input  wire logic [9:0]  txn_actual,
	output logic      [1:0]  functional_state_field
);
	typedef enum logic [1:0] {bus_reset_state, waking_state, running_state, sleeping_state} fs_e;
	typedef enum logic [2:0] {e_idle, e_hdr, e_eval, e_txn, e_wb, e_next} walk_e;

	typedef struct packed {
		logic [19:0]          sync1;
		logic [19:0]          sync2;
		logic                 rd_d;
		logic                 wr_d;
		logic                 rd_act;
		logic                 wr_act;
		logic [7:0]           cmd;
		logic                 hi;
		logic [15:0]          lo;
		logic [31:0]          ctrl;
		fs_e                  fs;
		logic [31:0]          cmdst;
		logic [31:0]          fmint;
		logic [15:0]          iso_len;
		logic [15:0]          gen_len;
		logic [15:0]          hwcfg;
		logic [31:0]          core_en;
		logic [5:0]           proc_en;
		logic [AW-1:0]        bptr;
		logic [15:0]          dout;
		logic                 irq_lat;
		logic                 irq_lat_d;
		logic                 pin;
		walk_e                est;
		logic [AW-1:0]        eaddr;
		logic [1:0]           eidx;
		logic                 rdv;
		logic [3:0][15:0]     hdr;
	} state_s;

	localparam state_s RESET_S = '{sync1: '1, sync2: '1, rd_d: 1'b1, wr_d: 1'b1,
		ctrl: hc_irq_pkg::RST_WORD32, fs: bus_reset_state, cmdst: hc_irq_pkg::RST_WORD32,
		fmint: hc_irq_pkg::RST_FMINT, iso_len: hc_irq_pkg::RST_WORD16,
		gen_len: hc_irq_pkg::RST_WORD16, hwcfg: hc_irq_pkg::RST_WORD16,
		core_en: hc_irq_pkg::RST_WORD32, est: e_idle, default: '0};

	state_s s;
	state_s next_s;

	// 32-bit registers take two data phases, lower word first
	function automatic logic is_wide(input logic [7:0] idx);
		logic [7:0] r;
		r = idx & ~hc_irq_pkg::WRITE_FLAG;
		return (r == hc_irq_pkg::IDX_CONTROL) || (r == hc_irq_pkg::IDX_CMDSTAT) ||
			(r == hc_irq_pkg::IDX_CORE_ST) || (r == hc_irq_pkg::IDX_CORE_EN) ||
			(r == hc_irq_pkg::IDX_FMINT);
	endfunction : is_wide

	function automatic logic [1:0] fs_code(input fs_e f);
		unique case (f)
			bus_reset_state: return hc_irq_pkg::FS_BUS_RESET;
			waking_state:    return hc_irq_pkg::FS_WAKING;
			running_state:   return hc_irq_pkg::FS_RUNNING;
			sleeping_state:  return hc_irq_pkg::FS_SLEEPING;
		endcase
	endfunction : fs_code

	function automatic fs_e fs_decode(input logic [1:0] c);
		unique case (c)
			hc_irq_pkg::FS_BUS_RESET: return bus_reset_state;
			hc_irq_pkg::FS_WAKING:    return waking_state;
			hc_irq_pkg::FS_RUNNING:   return running_state;
			hc_irq_pkg::FS_SLEEPING:  return sleeping_state;
		endcase
	endfunction : fs_decode

	// synchronised pin views; sync1 feeds only sync2
	logic          cs_s, a0_s, rd_s, wr_s;
	logic [15:0]   d_s;
	assign {cs_s, a0_s, rd_s, wr_s, d_s} = s.sync2;

	logic          rd_fall, rd_rise, wr_fall, wr_rise;
	logic          data_wr, cmd_wr, soft_rst, core_rst;
	logic          buf_we, wb_we, buf_sel;
	logic [31:0]   wval;
	logic [31:0]   rval;
	logic [15:0]   a_rdata, b_rdata;
	logic [AW-1:0] b_addr;
	logic [5:0]    core_st, proc_st, proc_ev;
	logic          core_sum, proc_sum;
	logic          core_clr_we, proc_clr_we;
	logic [AW-1:0] reg_lo, reg_hi, step;

	assign rd_fall  = s.rd_d & ~rd_s;
	assign rd_rise  = ~s.rd_d & rd_s;
	assign wr_fall  = s.wr_d & ~wr_s;
	assign wr_rise  = ~s.wr_d & wr_s;
	assign cmd_wr   = wr_rise & s.wr_act & a0_s;
	assign data_wr  = wr_rise & s.wr_act & ~a0_s;
	assign soft_rst = cmd_wr && (d_s[7:0] == hc_irq_pkg::CMD_SOFT_RST);
	assign buf_sel  = (s.cmd & ~hc_irq_pkg::WRITE_FLAG) == hc_irq_pkg::IDX_BUFFER;
	assign buf_we   = data_wr & buf_sel & s.cmd[7];
	assign wval     = is_wide(s.cmd) ? {d_s, s.lo} : {16'h0000, d_s};
	// a write completes on the second phase for wide registers
	logic reg_commit;
	assign reg_commit  = data_wr & ~buf_sel & s.cmd[7] & (s.hi | ~is_wide(s.cmd));
	assign core_rst    = reg_commit && (s.cmd == (hc_irq_pkg::IDX_CMDSTAT | hc_irq_pkg::WRITE_FLAG))
		&& wval[hc_irq_pkg::CORE_RST_BIT];
	assign core_clr_we = reg_commit && (s.cmd == (hc_irq_pkg::IDX_CORE_ST | hc_irq_pkg::WRITE_FLAG));
	assign proc_clr_we = reg_commit && (s.cmd == (hc_irq_pkg::IDX_PROC_ST | hc_irq_pkg::WRITE_FLAG));
	assign proc_ev     = {core_sum, proc_events};

	irq_group #(.N(hc_irq_pkg::GROUP_N)) u_core_group (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.clr_all  (soft_rst | core_rst),
		.events   (core_events),
		.clr_we   (core_clr_we),
		.clr_bits (wval[5:0]),
		.enable   (s.core_en[5:0]),
		.gate     (s.core_en[hc_irq_pkg::MASTER_EN_BIT]),
		.status   (core_st),
		.summary  (core_sum)
	);

	irq_group #(.N(hc_irq_pkg::GROUP_N)) u_proc_group (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.clr_all  (soft_rst),
		.events   (proc_ev),
		.clr_we   (proc_clr_we),
		.clr_bits (wval[5:0]),
		.enable   (s.proc_en),
		.gate     (1'b1),
		.status   (proc_st),
		.summary  (proc_sum)
	);

	buffer_ram #(.AW(AW), .DW(16)) u_ram (
		.clk     (clk),
		.ce      (ce),
		.a_we    (buf_we),
		.a_addr  (s.bptr),
		.a_wdata (d_s),
		.a_rdata (a_rdata),
		.b_we    (wb_we),
		.b_addr  (b_addr),
		.b_wdata (s.hdr[0]),
		.b_rdata (b_rdata)
	);

	always_comb begin
		rval = 32'h0000_0000;
		unique case (s.cmd)
			hc_irq_pkg::IDX_CONTROL: begin
				rval = s.ctrl;
				rval[hc_irq_pkg::FS_LSB +: 2] = fs_code(s.fs);
			end
			hc_irq_pkg::IDX_CMDSTAT: rval = s.cmdst;
			hc_irq_pkg::IDX_CORE_ST: rval = {26'h0, core_st};
			hc_irq_pkg::IDX_CORE_EN: rval = s.core_en;
			hc_irq_pkg::IDX_FMINT:   rval = s.fmint;
			hc_irq_pkg::IDX_HWCFG:   rval = {16'h0000, s.hwcfg};
			hc_irq_pkg::IDX_PROC_ST: rval = {26'h0, proc_st};
			hc_irq_pkg::IDX_PROC_EN: rval = {26'h0, s.proc_en};
			hc_irq_pkg::IDX_ISO_LEN: rval = {16'h0000, s.iso_len};
			hc_irq_pkg::IDX_GEN_LEN: rval = {16'h0000, s.gen_len};
			default:                 rval = 32'h0000_0000;
		endcase
	end

	// general region sits after the isochronous region, in words
	assign reg_lo = AW'(s.iso_len >> 1);
	assign reg_hi = AW'((17'(s.iso_len) + 17'(s.gen_len)) >> 1);
	// header plus payload rounded up to whole double words
	assign step   = AW'(hc_irq_pkg::HDR_WORDS) + AW'(((11'(s.hdr[2][9:0]) + 11'd3) >> 2) << 1);
	assign b_addr = s.eaddr + AW'(s.eidx);
	assign wb_we  = (s.est == e_wb);

	always_comb begin
		next_s = s;
		next_s.sync1 = {cs_n, a0, rd_n, wr_n, data_in};
		next_s.sync2 = s.sync1;
		next_s.rd_d  = rd_s;
		next_s.wr_d  = wr_s;
		if (rd_fall && !cs_s && !a0_s) begin
			next_s.rd_act = 1'b1;
			next_s.dout   = buf_sel ? a_rdata : (s.hi ? rval[31:16] : rval[15:0]);
		end
		if (rd_rise) begin
			next_s.rd_act = 1'b0;
			if (s.rd_act && buf_sel)
				next_s.bptr = s.bptr + 1'b1;
			else if (s.rd_act && is_wide(s.cmd))
				next_s.hi = ~s.hi;
		end
		if (wr_fall)
			next_s.wr_act = ~cs_s;
		if (wr_rise)
			next_s.wr_act = 1'b0;
		if (cmd_wr) begin
			next_s.cmd = d_s[7:0];
			next_s.hi  = 1'b0;
			if ((d_s[7:0] & ~hc_irq_pkg::WRITE_FLAG) == hc_irq_pkg::IDX_BUFFER)
				next_s.bptr = '0;
		end
		if (buf_we)
			next_s.bptr = s.bptr + 1'b1;
		else if (data_wr && s.cmd[7] && is_wide(s.cmd) && !s.hi) begin
			next_s.lo = d_s;
			next_s.hi = 1'b1;
		end
		if (reg_commit) begin
			next_s.hi = 1'b0;
			unique case (s.cmd & ~hc_irq_pkg::WRITE_FLAG)
				hc_irq_pkg::IDX_CONTROL: begin
					next_s.ctrl = wval;
					next_s.fs   = fs_decode(wval[hc_irq_pkg::FS_LSB +: 2]);
				end
				hc_irq_pkg::IDX_CORE_EN: next_s.core_en = wval;
				hc_irq_pkg::IDX_FMINT:   next_s.fmint   = wval;
				hc_irq_pkg::IDX_HWCFG:   next_s.hwcfg   = wval[15:0];
				hc_irq_pkg::IDX_PROC_EN: next_s.proc_en = wval[5:0];
				hc_irq_pkg::IDX_ISO_LEN: next_s.iso_len = wval[15:0];
				hc_irq_pkg::IDX_GEN_LEN: next_s.gen_len = wval[15:0];
				default: ;
			endcase
		end

		// pin latch follows the tree only while enabled, else holds
		if (s.hwcfg[hc_irq_pkg::PIN_EN_BIT])
			next_s.irq_lat = proc_sum;
		next_s.irq_lat_d = s.irq_lat;
		if (s.hwcfg[hc_irq_pkg::TRIG_BIT])
			next_s.pin = s.irq_lat & ~s.irq_lat_d;
		else
			next_s.pin = s.irq_lat;

		unique case (s.est)
			e_idle: begin
				// a frame starts a walk only while running
				if (frame_tick && s.fs == running_state && reg_hi > reg_lo) begin
					next_s.eaddr = reg_lo;
					next_s.eidx  = '0;
					next_s.est   = e_hdr;
				end
			end
			e_hdr: begin
				next_s.rdv = ~s.rdv;
				if (s.rdv) begin
					next_s.hdr[s.eidx] = b_rdata;
					next_s.eidx        = s.eidx + 1'b1;
					if (s.eidx == 2'(hc_irq_pkg::HDR_WORDS - 1))
						next_s.est = e_eval;
				end
			end
			e_eval: next_s.est = s.hdr[0][hc_irq_pkg::HDR_ACT_BIT] ? e_txn : e_next;
			e_txn: begin
				if (txn_done) begin
					next_s.hdr[0][hc_irq_pkg::HDR_CC_LSB +: 4] = txn_code;
					next_s.hdr[0][9:0]                         = txn_actual;
					next_s.hdr[0][hc_irq_pkg::HDR_ACT_BIT]     = 1'b0;
					next_s.hdr[0][hc_irq_pkg::HDR_TGL_BIT]     = ~s.hdr[0][hc_irq_pkg::HDR_TGL_BIT];
					next_s.eidx = '0;
					next_s.est  = e_wb;
				end
			end
			e_wb: next_s.est = e_next;
			e_next: begin
				// the next header follows this record's payload
				next_s.eaddr = s.eaddr + step;
				next_s.eidx  = '0;
				if (s.hdr[1][hc_irq_pkg::HDR_LAST] || s.fs != running_state ||
					s.eaddr + step >= reg_hi)
					next_s.est = e_idle;
				else
					next_s.est = e_hdr;
			end
			default: next_s.est = e_idle;
		endcase

		if (core_rst) begin
			// controller reset leaves the port and pin setup alone
			next_s.ctrl    = hc_irq_pkg::RST_WORD32;
			next_s.fs      = sleeping_state;
			next_s.core_en = hc_irq_pkg::RST_WORD32;
			next_s.fmint   = hc_irq_pkg::RST_FMINT;
			next_s.est     = e_idle;
			next_s.rdv     = 1'b0;
		end
		if (soft_rst) begin
			// pin pipeline keeps running so no strobe edge is lost or seen twice
			next_s       = RESET_S;
			next_s.sync1 = {cs_n, a0, rd_n, wr_n, data_in};
			next_s.sync2 = s.sync1;
			next_s.rd_d  = rd_s;
			next_s.wr_d  = wr_s;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			s <= RESET_S;
		else if (ce)
			s <= next_s;
	end

	assign data_out       = s.dout;
	assign data_oe        = ~cs_s & ~a0_s & ~rd_s;
	assign int_pin        = s.hwcfg[hc_irq_pkg::POL_BIT] ? s.pin : ~s.pin;
	assign txn_req        = (s.est == e_txn);
	assign txn_func_addr  = s.hdr[3][6:0];
	assign txn_endpoint   = s.hdr[1][hc_irq_pkg::HDR_EP_LSB +: 4];
	assign txn_pid        = s.hdr[2][hc_irq_pkg::HDR_PID_LSB +: 2];
	assign txn_length     = s.hdr[2][9:0];
	assign txn_max_packet = s.hdr[1][9:0];
	assign txn_toggle     = s.hdr[0][hc_irq_pkg::HDR_TGL_BIT];
	assign txn_low_speed  = s.hdr[1][hc_irq_pkg::HDR_SPEED];
	assign functional_state_field = fs_code(s.fs);
endmodule : hc_irq_state_ctrl
`default_nettype wire

// File: tb/hc_irq_assertions.sv
// concurrent checks on the interrupt pin, functional state and transfer handshake
`timescale 1ns/1ps
`default_nettype none
module hc_irq_assertions (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [5:0] core_events,
	input wire logic [4:0] proc_events,
	input wire logic       frame_tick,
	input wire logic       txn_req,
	input wire logic       txn_done,
	input wire logic       data_oe,
	input wire logic       int_pin,
	input wire logic [1:0] functional_state_field
);
	// cycles since the last possible cause; saturating so long idle runs stay quiet
	logic [7:0] wr_quiet;
	logic [7:0] ev_quiet;
	logic [7:0] tick_quiet;
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_quiet   <= 8'hff;
			ev_quiet   <= 8'hff;
			tick_quiet <= 8'hff;
		end else begin
			wr_quiet   <= !wr_n ? 8'h00 : wr_quiet + 8'(wr_quiet != 8'hff);
			ev_quiet   <= |{core_events, proc_events} ? 8'h00 : ev_quiet + 8'(ev_quiet != 8'hff);
			tick_quiet <= frame_tick ? 8'h00 : tick_quiet + 8'(tick_quiet != 8'hff);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RST_OUT: assert property ($fell(rst) |-> int_pin && !txn_req && !data_oe
		&& functional_state_field == hc_irq_pkg::FS_BUS_RESET) else $error("bad reset outputs");
	AST_TXN_RUN: assert property ($rose(txn_req) |->
		functional_state_field == hc_irq_pkg::FS_RUNNING) else $error("transfer while not running");
	AST_TXN_HOLD: assert property (txn_req && !txn_done |=> txn_req)
		else $error("transfer request dropped early");
	AST_TXN_END: assert property (txn_req && txn_done |=> !txn_req [*3])
		else $error("transfer request kept after done");
	AST_TXN_CAUSE: assert property ($rose(txn_req) |-> tick_quiet < 8'd40)
		else $error("transfer without frame start");
	AST_OE_IDLE: assert property (rd_n [*3] |=> !data_oe)
		else $error("data bus driven without read strobe");
	AST_FS_CAUSE: assert property ($changed(functional_state_field) |->
		wr_quiet < 8'd12 || tick_quiet < 8'd200) else $error("state changed without write");
	AST_PIN_CAUSE: assert property ($changed(int_pin) |-> wr_quiet < 8'd16 || ev_quiet < 8'd16)
		else $error("interrupt pin moved without cause");
	COV_TXN: cover property ($rose(txn_req));
	COV_PIN: cover property ($rose(int_pin));
	COV_RUN: cover property (functional_state_field == hc_irq_pkg::FS_RUNNING);
endmodule : hc_irq_assertions
bind hc_irq_state_ctrl hc_irq_assertions chk (.clk(clk), .rst(rst), .rd_n(rd_n), .wr_n(wr_n),
	.core_events(core_events), .proc_events(proc_events), .frame_tick(frame_tick),
	.txn_req(txn_req), .txn_done(txn_done), .data_oe(data_oe), .int_pin(int_pin),
	.functional_state_field(functional_state_field));
`default_nettype wire

// File: tb/host_cpu_model.sv
// model of the processor on the register port and of the far end of each transfer
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
	input  wire logic        clk,
	output var  logic        cs_n,
	output var  logic        a0,
	output var  logic        rd_n,
	output var  logic        wr_n,
	output var  logic [15:0] data_in,
	input  wire logic [15:0] data_out,
	input  wire logic        data_oe,
	input  wire logic        txn_req,
	output var  logic        txn_done,
	output var  logic [3:0]  txn_code,
	output var  logic [9:0]  txn_actual
);
	int         resp_wait = 6;
	logic [3:0] resp_code = 4'h4;
	logic [9:0] resp_len  = 10'h004;
	logic       oe_seen;
	// one pin phase; levels held five cycles as the device syncs pins over two stages
	task automatic cycle(input logic port, input logic wr, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge clk);
		cs_n    = 1'b0;
		a0      = port;
		data_in = d;
		if (wr) wr_n = 1'b0;
		else rd_n = 1'b0;
		repeat (5) @(negedge clk);
		q       = data_out;
		oe_seen = data_oe;
		wr_n    = 1'b1;
		rd_n    = 1'b1;
		repeat (4) @(negedge clk);
		cs_n    = 1'b1;
		data_in = ~d;
	endtask : cycle
	initial begin
		{cs_n, a0, rd_n, wr_n, data_in} = {4'hf, 16'hffff};
		{txn_done, txn_code, txn_actual} = {1'b0, 4'hf, 10'h3ff};
		forever begin
			@(negedge clk);
			if (txn_req) begin
				repeat (resp_wait) @(negedge clk);
				{txn_done, txn_code, txn_actual} = {1'b1, resp_code, resp_len};
				@(negedge clk);
				{txn_done, txn_code, txn_actual} = {1'b0, ~resp_code, ~resp_len};
				@(negedge clk);
			end
		end
	end
endmodule : host_cpu_model
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the interrupt tree, functional state and descriptor walk
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, rst, cs_n, a0, rd_n, wr_n, data_oe, int_pin, frame_tick;
	logic        txn_req, txn_toggle, txn_low_speed, txn_done, seen;
	logic [15:0] data_in, data_out;
	logic [5:0]  core_events;
	logic [4:0]  proc_events;
	logic [6:0]  txn_func_addr;
	logic [3:0]  txn_endpoint, txn_code;
	logic [1:0]  txn_pid, functional_state_field;
	logic [9:0]  txn_length, txn_max_packet, txn_actual;
	logic [63:0] rv;
	int          err_total = 0;
	int          n_compared = 0;
	localparam logic [63:0] SUM = 64'h1 << hc_irq_pkg::SUMMARY_BIT;
	hc_irq_state_ctrl dut (.clk(clk), .rst(rst), .ce(1'b1), .cs_n(cs_n), .a0(a0), .rd_n(rd_n),
		.wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.int_pin(int_pin), .core_events(core_events), .proc_events(proc_events),
		.frame_tick(frame_tick), .txn_req(txn_req), .txn_func_addr(txn_func_addr),
		.txn_endpoint(txn_endpoint), .txn_pid(txn_pid), .txn_length(txn_length),
		.txn_max_packet(txn_max_packet), .txn_toggle(txn_toggle), .txn_low_speed(txn_low_speed),
		.txn_done(txn_done), .txn_code(txn_code), .txn_actual(txn_actual),
		.functional_state_field(functional_state_field));
	host_cpu_model cpu (.clk(clk), .cs_n(cs_n), .a0(a0), .rd_n(rd_n), .wr_n(wr_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .txn_req(txn_req),
		.txn_done(txn_done), .txn_code(txn_code), .txn_actual(txn_actual));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic end_of_test;
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// command phase, then n data phases lower word first; bit 7 of the index means write
	task automatic reg_io(input logic [7:0] idx, input int n, input logic [63:0] d,
		output logic [63:0] q);
		logic [15:0] w;
		cpu.cycle(1'b1, 1'b1, {8'h00, idx}, w);
		q = 64'h0;
		for (int i = 0; i < n; i++) begin
			cpu.cycle(1'b0, idx[7], d[16*i+:16], w);
			q[16*i+:16] = w;
		end
	endtask : reg_io
	task automatic reg_wr(input logic [7:0] idx, input int n, input logic [63:0] d);
		logic [63:0] q;
		reg_io(idx | hc_irq_pkg::WRITE_FLAG, n, d, q);
	endtask : reg_wr
	task automatic reg_chk(input logic [7:0] idx, input int n, input logic [63:0] exp);
		logic [63:0] q;
		reg_io(idx, n, 64'h0, q);
		check(q, exp);
		check(64'(cpu.oe_seen), 64'h1);
	endtask : reg_chk
	task automatic wait_sig(input logic txn, input logic v);
		int k;
		for (k = 0; k < 300 && (txn ? txn_req : int_pin) !== v; k++) @(negedge clk);
		check(64'(txn ? txn_req : int_pin), 64'(v));
		if (k == 300) end_of_test;
	endtask : wait_sig
	task automatic pulse(input logic [5:0] c, input logic [4:0] p, input logic t);
		@(negedge clk);
		{core_events, proc_events, frame_tick} = {c, p, t};
		@(negedge clk);
		{core_events, proc_events, frame_tick} = 12'h000;
	endtask : pulse
	initial begin
		rst = 1'b1;
		{core_events, proc_events, frame_tick} = 12'h000;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check(64'(functional_state_field), 64'(hc_irq_pkg::FS_BUS_RESET));
		reg_chk(8'h01, 2, 64'(hc_irq_pkg::RST_WORD32));
		reg_chk(8'h0d, 2, 64'(hc_irq_pkg::RST_FMINT));
		reg_wr(8'h2a, 1, 64'h0);
		reg_wr(8'h2b, 1, 64'h10);
		reg_chk(8'h2b, 1, 64'h10);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h5);
		reg_wr(hc_irq_pkg::IDX_CORE_EN, 2, 64'h8000_003f);
		reg_wr(hc_irq_pkg::IDX_PROC_EN, 1, 64'h3f);
		reg_wr(8'h0d, 2, 64'h2ee0);
		for (int i = 0; i < 6; i++) begin
			pulse(6'h01 << i, 5'(6'h01 << i), 1'b0);
			wait_sig(1'b0, 1'b1);
			reg_chk(hc_irq_pkg::IDX_CORE_ST, 2, 64'h1 << i);
			reg_chk(hc_irq_pkg::IDX_PROC_ST, 1, SUM | (64'h1f & (64'h1 << i)));
			reg_wr(hc_irq_pkg::IDX_CORE_ST, 2, 64'h1 << i);
			reg_wr(hc_irq_pkg::IDX_PROC_ST, 1, 64'h3f);
			wait_sig(1'b0, 1'b0);
		end
		// master enable off: core status still records, summary must stay clear
		reg_wr(hc_irq_pkg::IDX_CORE_EN, 2, 64'h3f);
		pulse(6'h04, 5'h00, 1'b0);
		reg_chk(hc_irq_pkg::IDX_PROC_ST, 1, 64'h0);
		reg_chk(hc_irq_pkg::IDX_CORE_ST, 2, 64'h4);
		reg_wr(hc_irq_pkg::IDX_CORE_ST, 2, 64'h4);
		pulse(6'h00, 5'h02, 1'b0);
		wait_sig(1'b0, 1'b1);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h4);
		reg_wr(hc_irq_pkg::IDX_PROC_ST, 1, 64'h3f);
		reg_wr(hc_irq_pkg::IDX_PROC_EN, 1, 64'h0);
		check(64'(int_pin), 64'h1);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h5);
		wait_sig(1'b0, 1'b0);
		reg_wr(hc_irq_pkg::IDX_PROC_EN, 1, 64'h3f);
		pulse(6'h00, 5'h08, 1'b0);
		wait_sig(1'b0, 1'b1);
		reg_chk(hc_irq_pkg::IDX_HWCFG, 1, 64'h5);
		reg_wr(hc_irq_pkg::IDX_PROC_EN, 1, 64'h0);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h4);
		wait_sig(1'b0, 1'b0);
		pulse(6'h00, 5'h10, 1'b0);
		reg_wr(hc_irq_pkg::IDX_PROC_EN, 1, 64'h3f);
		check(64'(int_pin), 64'h0);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h5);
		wait_sig(1'b0, 1'b1);
		reg_chk(hc_irq_pkg::IDX_PROC_ST, 1, 64'h18);
		reg_wr(hc_irq_pkg::IDX_PROC_ST, 1, 64'h3f);
		wait_sig(1'b0, 1'b0);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h4);
		pulse(6'h00, 5'h01, 1'b0);
		reg_chk(hc_irq_pkg::IDX_PROC_ST, 1, 64'h1);
		check(64'(int_pin), 64'h0);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h5);
		wait_sig(1'b0, 1'b1);
		reg_wr(hc_irq_pkg::IDX_PROC_ST, 1, 64'h3f);
		// edge mode gives a one-clock pulse; low polarity inverts the idle level
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h7);
		pulse(6'h00, 5'h04, 1'b0);
		wait_sig(1'b0, 1'b1);
		@(negedge clk);
		check(64'(int_pin), 64'h0);
		reg_wr(hc_irq_pkg::IDX_PROC_ST, 1, 64'h3f);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h1);
		check(64'(int_pin), 64'h1);
		reg_wr(hc_irq_pkg::IDX_HWCFG, 1, 64'h5);
		// a frame start outside the running state must not reach the bus
		pulse(6'h00, 5'h00, 1'b1);
		seen = 1'b0;
		repeat (60) @(negedge clk) seen = seen | txn_req;
		check(64'(seen), 64'h0);
		reg_wr(hc_irq_pkg::IDX_BUFFER, 4, 64'h0005_0404_3808_0800);
		reg_wr(8'h01, 2, 64'({hc_irq_pkg::FS_RUNNING, 6'h00}));
		repeat (4) @(negedge clk);
		check(64'(functional_state_field), 64'(hc_irq_pkg::FS_RUNNING));
		pulse(6'h00, 5'h00, 1'b1);
		wait_sig(1'b1, 1'b1);
		rv = 64'({txn_func_addr, txn_endpoint, txn_pid, txn_length, txn_max_packet,
			txn_toggle, txn_low_speed});
		check(rv, 64'({7'h05, 4'h3, 2'h1, 10'h004, 10'h008, 2'b00}));
		wait_sig(1'b1, 1'b0);
		reg_chk(hc_irq_pkg::IDX_BUFFER, 1, 64'({cpu.resp_code, 2'b01, cpu.resp_len}));
		reg_wr(8'h02, 2, 64'h1 << hc_irq_pkg::CORE_RST_BIT);
		repeat (4) @(negedge clk);
		check(64'(functional_state_field), 64'(hc_irq_pkg::FS_SLEEPING));
		reg_chk(8'h0d, 2, 64'(hc_irq_pkg::RST_FMINT));
		reg_chk(8'h2b, 1, 64'h10);
		reg_io(8'ha9, 0, 64'h0, rv);
		reg_chk(8'h2b, 1, 64'h0);
		reg_chk(hc_irq_pkg::IDX_HWCFG, 1, 64'h0);
		check(64'(int_pin), 64'h1);
		end_of_test;
	end
endmodule : tb
`default_nettype wire
